// ---- src/sac_pkg.sv ----
// Constants, register map and state type for the serial audio/control port
package sac_pkg;
   localparam int              WORD_W       = 32;
   localparam int              FIFO_DEPTH   = 16;
   // Register byte offsets
   localparam logic [7:0]      OFS_CTRL     = 8'h00;
   localparam logic [7:0]      OFS_STAT     = 8'h04;
   localparam logic [7:0]      OFS_TXD      = 8'h08;
   localparam logic [7:0]      OFS_RXD      = 8'h0c;
   // Control field positions
   localparam int              B_FS_EDGE    = 17;
   localparam int              B_DEEP       = 16;
   localparam int              B_ON         = 15;
   localparam int              B_HALT       = 13;
   localparam int              B_RELEASE    = 12;
   localparam int              B_WHI        = 11;
   localparam int              B_WLO        = 10;
   localparam int              B_SMP        = 9;
   localparam int              B_CKE        = 8;
   localparam int              B_PEER_SELECT_USE       = 7;
   localparam int              B_CKP        = 6;
   localparam int              B_MASTER     = 5;
   localparam int              B_FRAMED     = 4;
   localparam int              B_AUDIO      = 3;
   localparam logic [31:0]     CTRL_RESET   = 32'h0000_0000;
   localparam logic [31:0]     CTRL_WMASK   = 32'h0003_bff8;
   // Status field positions
   localparam int              B_RXV        = 0;
   localparam int              B_TXE        = 1;
   localparam int              B_TXF        = 2;
   localparam int              B_BUSY       = 3;
   // Master bit timing in hclk cycles
   localparam logic [3:0]      HALF_CYC     = 4'h4;
   localparam logic [3:0]      PH_LAST      = 4'h7;
   // Word and channel lengths
   localparam logic [5:0]      LEN_8        = 6'h08;
   localparam logic [5:0]      LEN_16       = 6'h10;
   localparam logic [5:0]      LEN_24       = 6'h18;
   localparam logic [5:0]      LEN_32       = 6'h20;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SYNC  = 2'b01,
      ST_SHIFT = 2'b10
   } sac_state_t;
endpackage

// ---- src/sac_fifo.sv ----
// Parameterised valid/ready word FIFO
`timescale 1ns/1ps
module sac_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 16
) (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [W-1:0]               in_data,
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic [W-1:0]                    out_data,
   output logic [$clog2(DEPTH):0]          count
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0]   cnt_r;
   wire           push = in_valid & in_ready;
   wire           pop  = out_valid & out_ready;

   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem[rp_r];
   assign count     = cnt_r;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // sac_fifo

// ---- src/sac_port.sv ----
// Serial port with audio framing, AHB-Lite registers and transmit FIFO
// Summary of operation
// - Master framed sync pulse leads first bit by one bit, or coincides when set; a framed slave drives no sync.
// - Deep buffer setting selects 16-word FIFO, else single-word buffer.
// - Deep buffer setting changes only while the port is off.
// - With halt set, the port freezes while the processor idles.
// - Output release set stops driving the serial data pin.
// - Audio width bits pick data length and channel length.
// - Non-audio width bits pick 32, 16 or 8 bit words.
// - Master samples input at end or middle of output time.
// - Slave always samples at middle, ignoring sample phase.
// - Clock edge setting picks which clock transition changes output; framed mode ignores it.
// - Slave honours peer select pin only when select use is set.
// - Clock polarity setting gives idle high or idle low clock.
`timescale 1ns/1ps
module sac_port
   import sac_pkg::*;
(
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   input  wire logic                  cpu_idle,
   input  wire logic                  sck_in,
   output logic                       sck_out,
   output logic                       sck_oe,
   input  wire logic                  sdi,
   output logic                       serial_out_pin,
   output logic                       serial_out_pin_oe,
   input  wire logic                  peer_select_pin_in,
   output logic                       peer_select_pin_out,
   output logic                       peer_select_pin_oe
);
   import sac_pkg::*;

   logic [31:0]      ctrl_r, hrdata_r, rx_data_r, sh_r, rx_sh_r;
   logic             hreadyout_r, hresp_r, pend_r, pw_r, rx_valid_r, chan_r;
   logic [7:0]       pa_r;
   logic [2:0]       sy1_r, sy2_r;
   logic             sck_d_r;
   sac_state_t       state_r, state_nxt;
   logic [3:0]       ph_r, ph_nxt;
   logic [5:0]       bit_r, bit_nxt;
   logic [31:0]      sh_nxt;
   logic             sck_r, sdo_r, sdo_oe_r, sck_oe_r, ss_r, ss_oe_r;
   logic             tx_pop;
   logic             tx_valid;
   logic [31:0]      tx_data;
   logic             fifo_rdy;
   logic [4:0]       fifo_cnt;

   // Control fields
   wire on       = ctrl_r[B_ON];
   wire master   = ctrl_r[B_MASTER];
   wire framed   = ctrl_r[B_FRAMED];
   wire audio    = ctrl_r[B_AUDIO];
   wire shift_clock_polarity      = ctrl_r[B_CKP];
   wire deep     = ctrl_r[B_DEEP];
   wire cke_eff  = ctrl_r[B_CKE] & ~framed;
   wire smp_eff  = ctrl_r[B_SMP] & master;
   wire run      = on & ~(ctrl_r[B_HALT] & cpu_idle);
   wire [1:0] wsel = {ctrl_r[B_WHI], ctrl_r[B_WLO]};

   // Lengths: data bits and bits per word on the wire
   wire [5:0] plain_len = wsel[1] ? LEN_32 : (wsel[0] ? LEN_16 : LEN_8);
   wire [5:0] aud_dlen  = (wsel == 2'b11) ? LEN_24 : (wsel == 2'b10) ? LEN_32 : LEN_16;
   wire [5:0] aud_clen  = (wsel == 2'b00) ? LEN_16 : LEN_32;
   wire [5:0] dlen      = audio ? aud_dlen : plain_len;
   wire [5:0] wlen      = audio ? aud_clen : plain_len;
   wire [4:0] shamt     = 5'(6'd32 - dlen);

   // Bus decode
   wire ap_take  = hsel & hready & htrans[1];
   wire a_ctrl   = (pa_r == OFS_CTRL);
   wire a_stat   = (pa_r == OFS_STAT);
   wire a_txd    = (pa_r == OFS_TXD);
   wire a_rxd    = (pa_r == OFS_RXD);
   wire tx_rdy   = fifo_rdy & (deep | (fifo_cnt == 5'h00));
   wire tx_push  = pend_r & pw_r & a_txd & tx_rdy;
   wire done_acc = pend_r & ~(pw_r & a_txd & ~tx_rdy);
   wire ctrl_wr  = done_acc & pw_r & a_ctrl;
   wire rx_rd    = done_acc & ~pw_r & a_rxd;
   wire [31:0] ctrl_wv = (hwdata & CTRL_WMASK) | (ctrl_r & ~CTRL_WMASK);
   wire [31:0] ctrl_nv = on ? {ctrl_wv[31:B_DEEP+1], deep, ctrl_wv[B_DEEP-1:0]} : ctrl_wv;
   wire [31:0] stat_v  = {28'h0, state_r != ST_IDLE, ~tx_rdy, fifo_cnt == 5'h00, rx_valid_r};
   wire [31:0] rd_v    = a_ctrl ? ctrl_r : a_stat ? stat_v : a_rxd ? rx_data_r : 32'h0;

   // Synchronised link inputs
   wire sck_s   = sy2_r[0];
   wire sdi_s   = sy2_r[1];
   wire ss_s    = sy2_r[2];
   wire s_edge  = sck_s ^ sck_d_r;
   wire s_lead  = s_edge & (sck_d_r == shift_clock_polarity);
   wire s_trail = s_edge & (sck_s == shift_clock_polarity);
   wire s_samp  = cke_eff ? s_lead : s_trail;
   wire s_chg   = cke_eff ? s_trail : s_lead;
   wire s_sel   = ~ctrl_r[B_PEER_SELECT_USE] | ~ss_s;

   // Bit timing events
   wire m_mid   = (ph_r == HALF_CYC);
   wire m_end   = (ph_r == PH_LAST);
   wire in_sh   = (state_r == ST_SHIFT);
   wire last    = (bit_r == wlen - 6'h01);
   wire samp_ev = in_sh & (master ? (smp_eff ? m_end : m_mid) : s_samp);
   wire chg_ev  = in_sh & (master ? (m_end & ~last) : (s_chg & bit_r != 6'h00));
   wire done_ev = in_sh & last & (master ? m_end : s_samp);
   wire [31:0] rx_sh_nxt = samp_ev ? {rx_sh_r[30:0], sdi_s} : rx_sh_r;
   wire m_start = master & tx_valid;
   wire start   = run & (state_r == ST_IDLE) & (m_start | (~master & s_sel));
   wire sync_first = master & framed & ~ctrl_r[B_FS_EDGE];
   assign tx_pop = start & tx_valid;

   always_comb begin
      state_nxt = state_r;
      ph_nxt    = ph_r;
      bit_nxt   = bit_r;
      sh_nxt    = sh_r;
      if (!on) begin
         state_nxt = ST_IDLE;
         ph_nxt    = 4'h0;
         bit_nxt   = 6'h00;
      end else if (run) begin
         case (state_r)
            ST_IDLE: begin
               if (start) begin
                  state_nxt = sync_first ? ST_SYNC : ST_SHIFT;
                  ph_nxt    = 4'h0;
                  bit_nxt   = 6'h00;
                  sh_nxt    = tx_valid ? (tx_data << shamt) : 32'h0;
               end
            end
            ST_SYNC: begin
               ph_nxt = ph_r + 4'h1;
               if (m_end) begin
                  state_nxt = ST_SHIFT;
                  ph_nxt    = 4'h0;
               end
            end
            default: begin
               if (master) begin
                  ph_nxt = m_end ? 4'h0 : ph_r + 4'h1;
               end
               if (!master && ctrl_r[B_PEER_SELECT_USE] && ss_s) begin
                  state_nxt = ST_IDLE;
               end else if (done_ev) begin
                  state_nxt = ST_IDLE;
               end else if (master ? m_end : s_samp) begin
                  bit_nxt = bit_r + 6'h01;
               end
               if (chg_ev) begin
                  sh_nxt = {sh_r[30:0], 1'b0};
               end
            end
         endcase
      end
   end

   wire half_nxt = (ph_nxt >= HALF_CYC);
   wire sck_lvl  = shift_clock_polarity ^ (half_nxt == cke_eff);
   wire sh_act   = (state_nxt == ST_SHIFT);
   wire fs_nxt   = (state_nxt == ST_SYNC) |
                   (sh_act & framed & ctrl_r[B_FS_EDGE] & bit_nxt == 6'h00);
   wire ss_nxt   = framed ? fs_nxt : audio ? chan_r : ~sh_act;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sy1_r   <= 3'h0;
         sy2_r   <= 3'h0;
         sck_d_r <= 1'b0;
      end else begin
         sy1_r   <= {peer_select_pin_in, sdi, sck_in};
         sy2_r   <= sy1_r;
         sck_d_r <= sy2_r[0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_r      <= 1'b0;
         pw_r        <= 1'b0;
         pa_r        <= 8'h00;
         hreadyout_r <= 1'b1;
         hrdata_r    <= 32'h0;
         hresp_r     <= 1'b0;
         ctrl_r      <= CTRL_RESET;
         rx_valid_r  <= 1'b0;
         rx_data_r   <= 32'h0;
      end else begin
         if (ap_take) begin
            pend_r      <= 1'b1;
            pw_r        <= hwrite;
            pa_r        <= haddr[7:0];
            hreadyout_r <= 1'b0;
         end else if (done_acc) begin
            pend_r      <= 1'b0;
            hreadyout_r <= 1'b1;
            hrdata_r    <= pw_r ? 32'h0 : rd_v;
         end
         if (ctrl_wr) begin
            ctrl_r <= ctrl_nv;
         end
         if (run & done_ev) begin
            rx_data_r  <= rx_sh_nxt;
            rx_valid_r <= 1'b1;
         end else if (rx_rd) begin
            rx_valid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r  <= ST_IDLE;
         ph_r     <= 4'h0;
         bit_r    <= 6'h00;
         sh_r     <= 32'h0;
         rx_sh_r  <= 32'h0;
         chan_r   <= 1'b0;
         sck_r    <= 1'b0;
         sck_oe_r <= 1'b0;
         sdo_r    <= 1'b0;
         sdo_oe_r <= 1'b0;
         ss_r     <= 1'b1;
         ss_oe_r  <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         ph_r     <= ph_nxt;
         bit_r    <= bit_nxt;
         sh_r     <= sh_nxt;
         rx_sh_r  <= start ? 32'h0 : (run & samp_ev) ? rx_sh_nxt : rx_sh_r;
         chan_r   <= (!on) ? 1'b0 : chan_r ^ (run & done_ev & audio);
         sck_r    <= (sh_act & master) ? sck_lvl : shift_clock_polarity;
         sck_oe_r <= on & master;
         sdo_r    <= sh_nxt[31];
         sdo_oe_r <= on & ~ctrl_r[B_RELEASE];
         ss_r     <= ss_nxt;
         ss_oe_r  <= on & master & (framed | audio | ctrl_r[B_PEER_SELECT_USE]);
      end
   end

   sac_fifo #(
      .W     (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_txq (
      .clk       (hclk),
      .rst_n     (hresetn),
      .in_valid  (tx_push),
      .in_ready  (fifo_rdy),
      .in_data   (hwdata),
      .out_valid (tx_valid),
      .out_ready (tx_pop),
      .out_data  (tx_data),
      .count     (fifo_cnt)
   );

   assign hrdata              = hrdata_r;
   assign hreadyout           = hreadyout_r;
   assign hresp               = hresp_r;
   assign sck_out             = sck_r;
   assign sck_oe              = sck_oe_r;
   assign serial_out_pin      = sdo_r;
   assign serial_out_pin_oe   = sdo_oe_r;
   assign peer_select_pin_out = ss_r;
   assign peer_select_pin_oe  = ss_oe_r;

   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   fs_lead_a: assert property (state_r == ST_SYNC && m_end && run |=>
      state_r == ST_SHIFT && $past(ss_r) && !ss_r)
      else $error("sync not ahead of first bit");
   single_buf_a: assert property (!deep && fifo_cnt != 5'h00 |-> !tx_push)
      else $error("single buffer took second word");
   deep_lock_a: assert property (ctrl_wr && on |=> deep == $past(deep))
      else $error("buffer mode changed while on");
   idle_halt_a: assert property (on && ctrl_r[B_HALT] && cpu_idle |=>
      $stable(ph_r) && $stable(bit_r)) else $error("port ran in cpu idle");
   out_rel_a: assert property (on && ctrl_r[B_RELEASE] |=> !serial_out_pin_oe)
      else $error("data pin driven while released");
   aud_len_a: assert property (audio && wsel == 2'b00 && done_ev |-> bit_r == 6'h0f)
      else $error("audio 16 bit channel length wrong");
   word_len_a: assert property (!audio && wsel == 2'b01 && done_ev |-> bit_r == 6'h0f)
      else $error("16 bit word length wrong");
   m_sample_a: assert property (master && samp_ev |-> ph_r == (smp_eff ? PH_LAST : HALF_CYC))
      else $error("master sample phase wrong");
   s_sample_a: assert property (!master && samp_ev |-> s_edge && (cke_eff ? s_lead : s_trail))
      else $error("slave sampled off middle edge");
   out_edge_a: assert property (master && chg_ev && run |=> ph_r == 4'h0 ##1
      sck_out == (cke_eff ? shift_clock_polarity : !shift_clock_polarity)) else $error("data changed on wrong edge");
   sel_drop_a: assert property (!master && ctrl_r[B_PEER_SELECT_USE] && ss_s && on |=>
      state_r == ST_IDLE) else $error("slave ran unselected");
   clk_idle_a: assert property (state_r == ST_IDLE [*2] |-> sck_out == $past(shift_clock_polarity))
      else $error("clock idle level wrong");
   off_idle_a: assert property (!on |=> state_r == ST_IDLE && !sck_oe && !serial_out_pin_oe)
      else $error("port active while off");

   master_cv: cover property (master && done_ev);
   slave_cv:  cover property (!master && done_ev);
   framed_cv: cover property (framed && state_r == ST_SYNC);
   full_cv:   cover property (!fifo_rdy);
endmodule // sac_port

// ---- verif/sac_peer.sv ----
// Far-side serial peer: shifts data both ways with the port
`timescale 1ns/1ps
module sac_peer (
   input  wire logic hclk,
   input  wire logic sck_out,
   input  wire logic sout,
   input  wire logic sync,
   input  wire logic shift_clock_polarity,
   input  wire logic cke,
   output logic      sck_in,
   output logic      sdi,
   output logic      ps_in
);
   logic [63:0] cap;
   logic [31:0] pat = 32'ha53c_96f1;
   int          nbits = 0;
   int          nchg = 0;
   logic        sync0;
   logic        sdi_s = 1'b0;
   logic        sck_d = 1'b0;
   logic        tog = 1'b0;
   logic        slv = 1'b0;
   logic        sel_n = 1'b1;
   initial sck_in = 1'b0;  // Link clock still outside frames
   assign ps_in = sel_n;
   assign sdi = slv ? sdi_s : (nchg > 0 && nchg < 33) ? pat[32-nchg] : tog;
   always @(posedge hclk) begin
      tog <= ~tog;  // Unused input keeps changing
      sck_d <= sck_out;
      if (sck_out !== sck_d && sck_out === (shift_clock_polarity ^ cke)) begin
         if (nbits == 0) sync0 <= sync;
         if (nbits < 64) cap[63-nbits] <= sout;
         nbits <= nbits + 1;
      end else if (sck_out !== sck_d) begin
         nchg <= nchg + 1;
      end
   end
   task automatic clear();
      nbits = 0;
      nchg = 0;
   endtask
   task automatic slave_word(input logic [7:0] v);
      slv = 1'b1;
      sel_n = 1'b0;
      #37;
      for (int i = 7; i >= 0; i--) begin
         sdi_s = v[i];
         sck_in = 1'b1;
         #100;
         sck_in = 1'b0;  // Middle edge, port samples here
         #100;
      end
      slv = 1'b0;
      sel_n = 1'b1;
   endtask
endmodule  // sac_peer

// ---- verif/spi_audio_serial_control_test.sv ----
// Self-checking bench for the serial audio/control port
`timescale 1ns/1ps
module spi_audio_serial_control_test;
   import sac_pkg::*;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] e;
      logic [31:0] c;
      logic [5:0]  n;
   } sac_row_t;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        cpu_idle = 1'b0;
   logic        shift_clock_polarity = 1'b0;
   logic        cke = 1'b0;
   logic [31:0] hrdata, r;
   logic        hreadyout, sck_in, sck_out, sck_oe, sdi, sout, sout_oe;
   logic        ps_in, ps_out, ps_oe, hresp;
   int          err_total = 0;
   int          tests_run = 0;
   sac_row_t    rows [15] = '{
      '{OFS_CTRL, 32'hffff_ffff, CTRL_WMASK, 32'h0, 6'h0},
      '{OFS_CTRL, 32'h0, 32'h0001_0000, 32'h0, 6'h0},
      '{OFS_CTRL, 32'h0, 32'h0, 32'h0, 6'h0},
      '{8'h10, 32'hffff_ffff, 32'h0, 32'h0, 6'h0},
      '{OFS_STAT, 32'hffff_ffff, 32'h2, 32'h0, 6'h0},
      '{OFS_RXD, 32'hffff_ffff, 32'h0, 32'h0, 6'h0},
      '{8'h0, 32'h9b2d_e417, 32'h17, 32'h8020, 6'd8},
      '{8'h0, 32'h9b2d_e417, 32'he417, 32'h8460, 6'd16},
      '{8'h0, 32'h9b2d_e417, 32'h9b2d_e417, 32'h8920, 6'd32},
      '{8'h0, 32'h9b2d_e417, 32'h9b2d_e417, 32'h8d60, 6'd32},
      '{8'h0, 32'h9b2d_e417, 32'h2de4_1700, 32'h8c28, 6'd32},
      '{8'h0, 32'h9b2d_e417, 32'h9b2d_e417, 32'h8828, 6'd32},
      '{8'h0, 32'h9b2d_e417, 32'he417_0000, 32'h8428, 6'd32},
      '{8'h0, 32'h9b2d_e417, 32'he417, 32'h8028, 6'd16},
      '{8'h0, 32'h9b2d_e417, 32'h17, 32'h8220, 6'd8}};
   sac_port u_sac_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_idle(cpu_idle),
      .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .sdi(sdi),
      .serial_out_pin(sout), .serial_out_pin_oe(sout_oe), .peer_select_pin_in(ps_in),
      .peer_select_pin_out(ps_out), .peer_select_pin_oe(ps_oe));
   sac_peer u_sac_peer (.hclk(hclk), .sck_out(sck_out), .sout(sout), .sync(ps_out),
      .shift_clock_polarity(shift_clock_polarity), .cke(cke), .sck_in(sck_in), .sdi(sdi), .ps_in(ps_in));
   always #12.5 hclk = ~hclk;
   task automatic report_and_stop();
      $display("tests run %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 4000);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 4000);
      r = hrdata;
      if (n >= 4000) err_total++;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(r, e);
   endtask
   task automatic ctl(input logic [31:0] v);
      bus(1'b1, OFS_CTRL, v);
      repeat (2) @(posedge hclk);
   endtask
   task automatic wait_bits(input int n);
      int k;
      k = 0;
      while (u_sac_peer.nbits < n && k < 20000) begin
         @(posedge hclk);
         k++;
      end
      if (k >= 20000) err_total++;
      repeat (24) @(posedge hclk);
   endtask
   initial begin
      #2_000_000;
      err_total++;
      report_and_stop();
   end
   initial begin
      repeat (2) @(posedge hclk);
      chk(32'({hreadyout, sck_oe, sout_oe, ps_oe, ps_out}), 32'h11);
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      cpu_idle <= 1'b1;
      rd(OFS_CTRL, CTRL_RESET);
      rd(OFS_STAT, 32'h2);
      chk(32'(hresp), 32'h0);
      $display("reset test done");
      foreach (rows[i]) begin
         if (rows[i].n == 6'h0) begin
            bus(1'b1, rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
         end else begin
            ctl(32'h0);
            shift_clock_polarity = rows[i].c[B_CKP];
            cke = rows[i].c[B_CKE];
            ctl(rows[i].c);
            u_sac_peer.clear();
            bus(1'b1, OFS_TXD, rows[i].d);
            wait_bits(32'(rows[i].n));
            chk(u_sac_peer.cap[63:32] >> (32 - rows[i].n), rows[i].e);
            if (rows[i].n == 6'd8) rd(OFS_RXD, 32'ha5);
         end
         $display("row %0d done", i);
      end
      for (int p = 0; p < 2; p++) begin
         shift_clock_polarity = p[0];
         cke = 1'b0;
         ctl(32'h8020 | (32'(p) << B_CKP));
         chk(32'({sck_out, sck_oe, sout_oe}), 32'({p[0], 2'b11}));
      end
      ctl(32'h9020);
      chk(32'(sout_oe), 32'h0);
      ctl(32'h0);
      chk(32'({sck_oe, sout_oe, ps_oe}), 32'h0);
      $display("pin test done");
      shift_clock_polarity = 1'b0;
      for (int f = 0; f < 2; f++) begin
         ctl(32'h0);
         ctl(32'h8030 | (32'(f) << B_FS_EDGE));
         u_sac_peer.clear();
         bus(1'b1, OFS_TXD, 32'h5a);
         wait_bits(8);
         chk(32'(u_sac_peer.sync0), 32'(f));
      end
      $display("frame test done");
      ctl(32'h0);
      ctl(32'ha020);
      u_sac_peer.clear();
      bus(1'b1, OFS_TXD, 32'h3c);
      repeat (200) @(posedge hclk);
      chk(32'(u_sac_peer.nbits), 32'h0);
      cpu_idle <= 1'b0;
      wait_bits(8);
      chk(32'(u_sac_peer.cap[63:56]), 32'h3c);
      $display("halt test done");
      ctl(32'h0);
      ctl(32'h8000);
      u_sac_peer.slave_word(8'h96);
      repeat (24) @(posedge hclk);
      rd(OFS_RXD, 32'h96);
      ctl(32'h0);
      ctl(32'h8080);
      bus(1'b0, OFS_STAT, 32'h0);
      chk(r & 32'h8, 32'h0);
      u_sac_peer.slave_word(8'h69);
      repeat (24) @(posedge hclk);
      rd(OFS_RXD, 32'h69);
      $display("slave test done");
      ctl(32'h0);
      ctl(32'h0001_0000);
      for (int i = 0; i < 16; i++) bus(1'b1, OFS_TXD, 32'(i));
      bus(1'b0, OFS_STAT, 32'h0);
      chk(r & 32'h6, 32'h4);
      u_sac_peer.clear();
      ctl(32'h0001_8020);
      wait_bits(128);
      bus(1'b0, OFS_STAT, 32'h0);
      chk(r & 32'h6, 32'h2);
      ctl(32'h8020);
      rd(OFS_CTRL, 32'h0001_8020);
      ctl(32'h0);
      ctl(32'h0);
      rd(OFS_CTRL, 32'h0);
      bus(1'b1, OFS_TXD, 32'h1);
      bus(1'b0, OFS_STAT, 32'h0);
      chk(r & 32'h6, 32'h4);
      $display("buffer test done");
      report_and_stop();
   end
endmodule  // spi_audio_serial_control_test
